/* cmrs_pkg.sv */
// Package for the CAN mailbox receive-status block: register map, fields, types
package cmrs_pkg;

  localparam int          NUM_MB        = 16;
  localparam logic [11:0] OFS_IRQ_FLAGS = 12'h000;
  localparam logic [11:0] OFS_OVERWRITE = 12'h004;
  localparam logic [11:0] OFS_MSG_CTRL1 = 12'h008;
  localparam logic [11:0] OFS_MB_MASK   = 12'h00C;
  localparam logic [11:0] OFS_REM_PEND  = 12'h010;
  localparam logic [11:0] OFS_RX_PEND   = 12'h014;
  localparam logic [11:0] OFS_BIT_TIME  = 12'h018;
  localparam logic [11:0] OFS_CONTROL   = 12'h01C;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h020;
  localparam logic [11:0] OFS_DECODE    = 12'h024;

  localparam int BIT_RESET_IRQ  = 0;
  localparam int BIT_RX_IRQ     = 9;
  localparam int BIT_REMOTE_IRQ = 10;

  localparam logic [15:0] RST_IRQ_FLAGS = 16'h0001;
  localparam logic [15:0] RST_OVERWRITE = 16'h0000;
  localparam logic [15:0] RST_MB_MASK   = 16'hFFFF;
  localparam logic [15:0] RST_IRQ_MASK  = 16'hFFFF;
  localparam logic [7:0]  RST_MSG_CTRL1 = 8'h00;
  localparam logic [15:0] RST_BIT_TIME  = 16'h0000;

  // Bit timing layout: prescaler [5:0], seg one [11:8], seg two [14:12]
  localparam int BT_BRP_LSB  = 0;
  localparam int BT_SEG1_LSB = 8;
  localparam int BT_SEG2_LSB = 12;
  localparam logic [4:0] SYNC_QUANTA = 5'h01;
  localparam logic [4:0] SEG1_MIN_Q  = 5'h04;
  localparam logic [4:0] SEG1_MAX_Q  = 5'h10;
  localparam logic [4:0] SEG2_MIN_Q  = 5'h02;
  localparam logic [4:0] SEG2_MAX_Q  = 5'h08;
  localparam logic [4:0] BIT_MIN_Q   = 5'h08;
  localparam logic [4:0] BIT_MAX_Q   = 5'h19;

  typedef struct packed {
    logic        valid;
    logic [3:0]  mailbox;
    logic        remote;
  } cmrs_rx_event_s;

  typedef struct packed {
    logic [5:0] baud_prescaler;
    logic [3:0] seg1;
    logic [2:0] seg2;
  } cmrs_bit_time_s;

  typedef enum logic [1:0] {
    CMRS_IDLE,
    CMRS_DATA
  } cmrs_bus_state_e;

  // Byte count for a data length code
  function automatic logic [3:0] dlc_bytes(input logic [3:0] code);
    dlc_bytes = code[3] ? 4'h8 : {1'b0, code[2:0]};
  endfunction : dlc_bytes

endpackage : cmrs_pkg

/* cmrs_bit_timing.sv */
// Bit-time quanta calculation and range check
`timescale 1ns/1ps
module cmrs_bit_timing
  import cmrs_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire cmrs_bit_time_s  cfg,
  output logic [4:0]           seg1_q,
  output logic [4:0]           seg2_q,
  output logic [4:0]           total_q,
  output logic                 valid
);

  logic [4:0] s1;
  logic [4:0] s2;
  logic [4:0] tot;
  logic       ok;

  always_comb
  begin
    s1  = {1'b0, cfg.seg1} + 5'h01;
    s2  = {2'b00, cfg.seg2} + 5'h01;
    tot = SYNC_QUANTA + s1 + s2;
    ok  = (s1 >= SEG1_MIN_Q) && (s1 <= SEG1_MAX_Q) && (s2 >= SEG2_MIN_Q) && (s2 <= SEG2_MAX_Q)
          && (tot >= BIT_MIN_Q) && (tot <= BIT_MAX_Q) && (cfg.baud_prescaler != 6'h00);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seg1_q  <= 5'h00;
      seg2_q  <= 5'h00;
      total_q <= 5'h00;
      valid   <= 1'b0;
    end
    else
    begin
      seg1_q  <= s1;
      seg2_q  <= s2;
      total_q <= tot;
      valid   <= ok;
    end
  end

endmodule : cmrs_bit_timing

/* cmrs_top.sv */
// CAN mailbox receive-status block with AHB-Lite register slave
`timescale 1ns/1ps
module cmrs_top
  import cmrs_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        RX_DONE,
  input  wire logic [3:0]  RX_MAILBOX,
  input  wire logic        RX_REMOTE,
  input  wire logic        STANDBY_EXIT,
  input  wire logic        MODULE_STOP_EXIT,
  output logic             RESET_MODE_REQ,
  output logic [3:0]       DATA_BYTES,
  output logic             BIT_TIME_OK,
  output logic [4:0]       BIT_QUANTA,
  output logic             IRQ
);

  logic            remote_flag_reg;
  logic            rx_flag_reg;
  logic            reset_flag_reg;
  logic [15:0]     flags_word;
  logic [15:0]     overwrite_reg;
  logic [7:0]      msg_ctrl1_reg;
  logic [15:0]     mb_mask_reg;
  logic [15:0]     rem_pend_reg;
  logic [15:0]     rx_pend_reg;
  logic [15:0]     bit_time_reg;
  logic            reset_req_reg;
  logic [15:0]     irq_mask_reg;
  logic [31:0]     rdata_reg;
  logic            irq_reg;
  logic [3:0]      bytes_reg;
  logic            bt_ok_reg;
  logic [4:0]      bt_q_reg;

  // Address phase capture
  logic            dp_write_reg;
  logic [11:0]     dp_addr_reg;
  cmrs_bus_state_e bus_state_reg;
  logic            hready_reg;
  logic            hresp_reg;

  // Two-stage synchronisers for pin-level event inputs
  logic [6:0]      sync1_reg;
  logic [6:0]      sync2_reg;
  logic [2:0]      pulse_prev_reg;
  logic [1:0]      done_sync_reg;
  logic            rx_done_sync;

  cmrs_rx_event_s  rx_ev;
  logic            rx_edge;
  logic            standby_edge;
  logic            mstop_edge;
  logic [15:0]     rx_onehot;
  logic            rx_unmasked;
  logic            wr_en;
  logic [15:0]     wdata16;
  logic [4:0]      seg1_q;
  logic [4:0]      seg2_q;
  logic [4:0]      total_q;
  logic            bt_valid;
  logic [15:0]     rx_pend_next;
  logic [15:0]     rem_pend_next;
  logic [15:0]     ow_clear;
  logic [15:0]     overwrite_next;
  logic [11:0]     rd_addr;
  logic [31:0]     rd_mux;

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sync1_reg      <= 7'h00;
      sync2_reg      <= 7'h00;
      pulse_prev_reg <= 3'h0;
    end
    else
    begin
      sync1_reg      <= {MODULE_STOP_EXIT, STANDBY_EXIT, RX_REMOTE, RX_MAILBOX};
      sync2_reg      <= sync1_reg;
      pulse_prev_reg <= {sync2_reg[6], sync2_reg[5], rx_done_sync};
    end
  end

  // Done strobe synchronised separately, through the same two stages as mailbox and type
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      done_sync_reg <= 2'b00;
    else
      done_sync_reg <= {done_sync_reg[0], RX_DONE};
  end
  assign rx_done_sync = done_sync_reg[1];

  assign rx_edge      = rx_done_sync & ~pulse_prev_reg[0];
  assign standby_edge = sync2_reg[5] & ~pulse_prev_reg[1];
  assign mstop_edge   = sync2_reg[6] & ~pulse_prev_reg[2];

  always_comb
  begin
    rx_ev.valid   = rx_edge;
    rx_ev.mailbox = sync2_reg[3:0];
    rx_ev.remote  = sync2_reg[4];
    rx_onehot     = rx_ev.valid ? (16'h0001 << rx_ev.mailbox) : 16'h0000;
    rx_unmasked   = |(rx_onehot & ~mb_mask_reg);
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      dp_write_reg  <= 1'b0;
      dp_addr_reg   <= 12'h000;
      bus_state_reg <= CMRS_IDLE;
    end
    else if (HREADY)
    begin
      dp_write_reg  <= HSEL & HTRANS[1] & HWRITE;
      dp_addr_reg   <= HADDR[11:0];
      bus_state_reg <= (HSEL & HTRANS[1]) ? CMRS_DATA : CMRS_IDLE;
    end
  end

  assign wr_en   = dp_write_reg && (bus_state_reg == CMRS_DATA);
  assign wdata16 = HWDATA[15:0];
  assign rd_addr = HADDR[11:0];

  // Software-written configuration registers
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      msg_ctrl1_reg <= RST_MSG_CTRL1;
      mb_mask_reg   <= RST_MB_MASK;
      bit_time_reg  <= RST_BIT_TIME;
      irq_mask_reg  <= RST_IRQ_MASK;
    end
    else if (wr_en)
    begin
      if (dp_addr_reg == OFS_MSG_CTRL1)
        msg_ctrl1_reg <= HWDATA[7:0];
      else if (dp_addr_reg == OFS_MB_MASK)
        mb_mask_reg <= wdata16;
      else if (dp_addr_reg == OFS_BIT_TIME)
        bit_time_reg <= wdata16;
      else if (dp_addr_reg == OFS_IRQ_MASK)
        irq_mask_reg <= wdata16;
    end
  end

  // Reset-request bit: set by reset, standby exit, software writing one
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      reset_req_reg <= 1'b1;
    else if (standby_edge)
      reset_req_reg <= 1'b1;
    else if (wr_en && dp_addr_reg == OFS_CONTROL)
      reset_req_reg <= HWDATA[0];
  end

  // Write-one-clear mask for the register at ofs; zero unless it is written now
  function automatic logic [15:0] w1c_mask(input logic [11:0] ofs, input logic wen, input logic [11:0] adr,
                                           input logic [15:0] data);
    w1c_mask = (wen && (adr == ofs)) ? data : 16'h0000;
  endfunction : w1c_mask

  // Next pending values; a reception in the clearing cycle keeps its bit
  always_comb
  begin
    ow_clear      = w1c_mask(OFS_OVERWRITE, wr_en, dp_addr_reg, wdata16);
    rx_pend_next  = (rx_pend_reg & ~w1c_mask(OFS_RX_PEND, wr_en, dp_addr_reg, wdata16)) | rx_onehot;
    rem_pend_next = (rem_pend_reg & ~w1c_mask(OFS_REM_PEND, wr_en, dp_addr_reg, wdata16))
                    | (rx_ev.remote ? rx_onehot : 16'h0000);
  end

  // Pending registers: reception sets, write one clears, set wins
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rx_pend_reg  <= 16'h0000;
      rem_pend_reg <= 16'h0000;
    end
    else
    begin
      rx_pend_reg  <= rx_pend_next;
      rem_pend_reg <= rem_pend_next;
    end
  end

  // One overwrite detector per mailbox: new message while its pending bit is still set
  for (genvar g = 0; g < NUM_MB; g++)
  begin : g_overwrite
    assign overwrite_next[g] = (rx_onehot[g] & rx_pend_reg[g]) | (overwrite_reg[g] & ~ow_clear[g]);
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      overwrite_reg <= RST_OVERWRITE;
    else
      overwrite_reg <= overwrite_next;
  end

  // Flags clear from the next pending word, so they track pending in the same cycle
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      remote_flag_reg <= RST_IRQ_FLAGS[BIT_REMOTE_IRQ];
    else if (rx_unmasked && rx_ev.remote)
      remote_flag_reg <= 1'b1;
    else if (rem_pend_next == 16'h0000)
      remote_flag_reg <= 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      rx_flag_reg <= RST_IRQ_FLAGS[BIT_RX_IRQ];
    else if (rx_unmasked)
      rx_flag_reg <= 1'b1;
    else if (rx_pend_next == 16'h0000)
      rx_flag_reg <= 1'b0;
  end

  // Reset flag: a recovery event wins over a software clear in the same cycle
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      reset_flag_reg <= RST_IRQ_FLAGS[BIT_RESET_IRQ];
    else if (standby_edge || mstop_edge)
      reset_flag_reg <= 1'b1;
    else if (wr_en && dp_addr_reg == OFS_IRQ_FLAGS && HWDATA[BIT_RESET_IRQ])
      reset_flag_reg <= 1'b0;
  end

  always_comb
  begin
    flags_word                 = 16'h0000;
    flags_word[BIT_RESET_IRQ]  = reset_flag_reg;
    flags_word[BIT_RX_IRQ]     = rx_flag_reg;
    flags_word[BIT_REMOTE_IRQ] = remote_flag_reg;
  end

  cmrs_bit_timing u_bit_timing (
    .clk     (CLK_SYS),
    .rst_n   (RSTN),
    .cfg     (cmrs_bit_time_s'{baud_prescaler: bit_time_reg[BT_BRP_LSB +: 6], seg1: bit_time_reg[BT_SEG1_LSB +: 4],
                               seg2: bit_time_reg[BT_SEG2_LSB +: 3]}),
    .seg1_q  (seg1_q),
    .seg2_q  (seg2_q),
    .total_q (total_q),
    .valid   (bt_valid)
  );

  // Read mux on the address-phase address; the result is registered into HRDATA
  always_comb
  begin
    if (rd_addr == OFS_IRQ_FLAGS)
      rd_mux = {16'h0000, flags_word};
    else if (rd_addr == OFS_OVERWRITE)
      rd_mux = {16'h0000, overwrite_reg};
    else if (rd_addr == OFS_MSG_CTRL1)
      rd_mux = {24'h000000, msg_ctrl1_reg};
    else if (rd_addr == OFS_MB_MASK)
      rd_mux = {16'h0000, mb_mask_reg};
    else if (rd_addr == OFS_REM_PEND)
      rd_mux = {16'h0000, rem_pend_reg};
    else if (rd_addr == OFS_RX_PEND)
      rd_mux = {16'h0000, rx_pend_reg};
    else if (rd_addr == OFS_BIT_TIME)
      rd_mux = {16'h0000, bit_time_reg};
    else if (rd_addr == OFS_CONTROL)
      rd_mux = {31'h00000000, reset_req_reg};
    else if (rd_addr == OFS_IRQ_MASK)
      rd_mux = {16'h0000, irq_mask_reg};
    else if (rd_addr == OFS_DECODE)
      rd_mux = {11'h000, bt_valid, total_q, seg2_q, seg1_q, 1'b0, dlc_bytes(msg_ctrl1_reg[3:0])};
    else
      rd_mux = 32'h00000000;
  end

  // Output registers
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      irq_reg   <= 1'b0;
      bytes_reg <= 4'h0;
      bt_ok_reg <= 1'b0;
      bt_q_reg  <= 5'h00;
    end
    else
    begin
      irq_reg   <= |(flags_word & ~irq_mask_reg);
      bytes_reg <= dlc_bytes(msg_ctrl1_reg[3:0]);
      bt_ok_reg <= bt_valid;
      bt_q_reg  <= total_q;
    end
  end

  // Read data captured at the address phase so it leaves a flop; limitation: a read
  // directly behind a write to the same register returns the value from before it
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      rdata_reg <= 32'h00000000;
    else if (HREADY)
      rdata_reg <= (HSEL && HTRANS[1] && !HWRITE) ? rd_mux : 32'h00000000;
  end

  // Zero wait states and OKAY, held in flops like every other output
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
    end
    else
    begin
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
    end
  end

  assign HRDATA         = rdata_reg;
  assign HREADYOUT      = hready_reg;
  assign HRESP          = hresp_reg;
  assign RESET_MODE_REQ = reset_req_reg;
  assign DATA_BYTES     = bytes_reg;
  assign BIT_TIME_OK    = bt_ok_reg;
  assign BIT_QUANTA     = bt_q_reg;
  assign IRQ            = irq_reg;

endmodule : cmrs_top

/* cmrs_can_node.sv */
// Far-side CAN node model that delivers completed receptions
`timescale 1ns/1ps
module cmrs_can_node
(
  input  wire logic       clk,
  output logic            rx_done    = 1'b0,
  output logic [3:0]      rx_mailbox = 4'h0,
  output logic            rx_remote  = 1'b0
);
  // Fields settle two cycles ahead of completion, since the block synchronises them
  task automatic receive(input logic [3:0] mb, input logic rem);
    rx_mailbox <= mb;
    rx_remote <= rem;
    repeat (2) @(posedge clk);
    rx_done <= 1'b1;
    repeat (2) @(posedge clk);
    rx_done <= 1'b0;
    repeat (2) @(posedge clk);
    // Released lines show the inverse, never the old value
    rx_mailbox <= ~mb;
    rx_remote <= ~rem;
    repeat (4) @(posedge clk);
  endtask : receive
endmodule : cmrs_can_node

/* cmrs_rx_monitor.sv */
// Bound assertions on the receive-status block ports
`timescale 1ns/1ps
module cmrs_rx_monitor
  import cmrs_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RSTN,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        RESET_MODE_REQ,
  input wire logic [3:0]  DATA_BYTES,
  input wire logic        BIT_TIME_OK,
  input wire logic [4:0]  BIT_QUANTA,
  input wire logic        IRQ
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  logic        act_reg, wr_reg;
  logic [11:0] adr_reg;
  logic [3:0]  bytes_reg;
  logic [4:0]  quanta_reg;
  wire         wr_dp = act_reg && wr_reg;
  wire         rd_dp = act_reg && !wr_reg;
  // Data-phase tracker pairs HWDATA with its address
  always_ff @(posedge CLK_SYS or negedge RSTN)
    if (!RSTN)
    begin
      act_reg <= 1'b0;
      wr_reg  <= 1'b0;
      adr_reg <= 12'h000;
    end
    else if (HREADY)
    begin
      act_reg <= HSEL && HTRANS[1];
      wr_reg  <= HWRITE;
      adr_reg <= HADDR[11:0];
    end
  always_ff @(posedge CLK_SYS)
    if (wr_dp && adr_reg == OFS_MSG_CTRL1)
      bytes_reg <= HWDATA[3] ? 4'h8 : {1'b0, HWDATA[2:0]};
  always_ff @(posedge CLK_SYS)
    if (wr_dp && adr_reg == OFS_BIT_TIME)
      quanta_reg <= {1'b0, HWDATA[11:8]} + {2'h0, HWDATA[14:12]} + 5'h03;
  property p_rst_req;
    $rose(RSTN) |-> RESET_MODE_REQ;
  endproperty
  a_rst_req: assert property (p_rst_req) else $error("reset request low after reset");
  property p_ctl_write;
    wr_dp && adr_reg == OFS_CONTROL && HWDATA[0] |=> ##[0:2] RESET_MODE_REQ;
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("reset request not set by write");
  property p_dlc;
    wr_dp && adr_reg == OFS_MSG_CTRL1 |=> ##[0:2] DATA_BYTES == bytes_reg;
  endproperty
  a_dlc: assert property (p_dlc) else $error("byte count decode wrong");
  property p_brp_zero;
    wr_dp && adr_reg == OFS_BIT_TIME && HWDATA[5:0] == 6'h00 |=> ##[0:2] !BIT_TIME_OK;
  endproperty
  a_brp_zero: assert property (p_brp_zero) else $error("zero prescaler accepted");
  property p_seg_sum;
    wr_dp && adr_reg == OFS_BIT_TIME && HWDATA[5:0] != 6'h00 |=> ##[0:2] BIT_QUANTA == quanta_reg;
  endproperty
  a_seg_sum: assert property (p_seg_sum) else $error("quanta total wrong");
  property p_quanta_range;
    BIT_TIME_OK |-> BIT_QUANTA >= BIT_MIN_Q && BIT_QUANTA <= BIT_MAX_Q;
  endproperty
  a_quanta_range: assert property (p_quanta_range) else $error("legal timing out of range");
  property p_flag_layout;
    rd_dp && adr_reg == OFS_IRQ_FLAGS |-> HRDATA[31:11] == 21'h000000 && HRDATA[8:1] == 8'h00;
  endproperty
  a_flag_layout: assert property (p_flag_layout) else $error("flag word has stray bits");
  property p_irq_masked;
    wr_dp && adr_reg == OFS_IRQ_MASK && HWDATA[15:0] == 16'hFFFF |=> ##[0:2] !IRQ;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt despite full mask");
  c_irq: cover property ($rose(IRQ));
  c_bt_ok: cover property ($rose(BIT_TIME_OK));
  c_dlc_max: cover property (DATA_BYTES == 4'h8);
endmodule : cmrs_rx_monitor

bind cmrs_top cmrs_rx_monitor cmrs_rx_monitor_inst (.CLK_SYS, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE,
  .HWDATA, .HREADY, .HRDATA, .RESET_MODE_REQ, .DATA_BYTES, .BIT_TIME_OK, .BIT_QUANTA, .IRQ);

/* can_mailbox_rx_status_bench.sv */
// Self-checking bench for the receive-status block
`timescale 1ns/1ps
module can_mailbox_rx_status_bench
  import cmrs_pkg::*;
;
  logic        CLK_SYS = 1'b0, RSTN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic        STANDBY_EXIT = 1'b0, MODULE_STOP_EXIT = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd, e, seed = 32'h56;
  logic [1:0]  HTRANS = 2'h0;
  logic        HREADYOUT, HRESP, RX_DONE, RX_REMOTE, RESET_MODE_REQ, BIT_TIME_OK, IRQ;
  logic [3:0]  RX_MAILBOX, DATA_BYTES, m, k;
  logic [4:0]  BIT_QUANTA;
  logic [15:0] bt;
  logic [15:0] corner [4] = '{16'h7F00, 16'h1301, 16'h1401, 16'h7F01};
  int          err_count = 0, compares = 0;
  wire         HREADY = HREADYOUT;

  always #12.5 CLK_SYS = ~CLK_SYS;

  cmrs_top cmrs_top_inst (.CLK_SYS, .RSTN, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY,
    .HRDATA, .HREADYOUT, .HRESP, .RX_DONE, .RX_MAILBOX, .RX_REMOTE, .STANDBY_EXIT, .MODULE_STOP_EXIT,
    .RESET_MODE_REQ, .DATA_BYTES, .BIT_TIME_OK, .BIT_QUANTA, .IRQ);
  cmrs_can_node cmrs_can_node_inst (.clk(CLK_SYS), .rx_done(RX_DONE), .rx_mailbox(RX_MAILBOX),
    .rx_remote(RX_REMOTE));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] exp_bytes(input logic [3:0] c);
    return c[3] ? 32'h8 : 32'(c[2:0]);
  endfunction : exp_bytes

  // Decode word fields: valid, total, segment two, segment one
  function automatic logic [31:0] exp_bt(input logic [15:0] b);
    logic [4:0] s1, s2, t;
    logic       ok;
    s1 = {1'b0, b[11:8]} + 5'h01;
    s2 = {2'h0, b[14:12]} + 5'h01;
    t = s1 + s2 + 5'h01;
    ok = b[5:0] != 6'h00 && s1 >= 5'h04 && s2 >= 5'h02 && t >= 5'h08 && t <= 5'h19;
    return {11'h000, ok, t, s2, s1, 5'h00};
  endfunction : exp_bt

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Master never assumes a latency; only the watchdog ends a stuck wait
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {20'h0, a};
    HWRITE <= w;
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
    rd = HRDATA;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask : rdc

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (5000) @(posedge CLK_SYS);
    err_count++;
    summarize();
  end

  initial
  begin
    repeat (12) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    @(posedge CLK_SYS);
    chk("reset request", 32'h1, 32'(RESET_MODE_REQ));
    chk("irq", 32'h0, 32'(IRQ));
    rdc("flags", OFS_IRQ_FLAGS, 32'h1);
    rdc("overwrite", OFS_OVERWRITE, 32'h0);
    wr(OFS_IRQ_FLAGS, 32'h600);
    rdc("flags", OFS_IRQ_FLAGS, 32'h1);
    wr(OFS_IRQ_FLAGS, 32'h1);
    wr(OFS_MB_MASK, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    rdc("flags", OFS_IRQ_FLAGS, 32'h0);
    rd = xs();
    m = rd[3:0];
    k = m ^ 4'h9;
    cmrs_can_node_inst.receive(m, 1'b0);
    rdc("flags", OFS_IRQ_FLAGS, 32'h200);
    chk("irq", 32'h1, 32'(IRQ));
    cmrs_can_node_inst.receive(m, 1'b0);
    rdc("overwrite", OFS_OVERWRITE, 32'h1 << m);
    wr(OFS_OVERWRITE, 32'h1 << m);
    rdc("overwrite", OFS_OVERWRITE, 32'h0);
    cmrs_can_node_inst.receive(k, 1'b0);
    rdc("rx pending", OFS_RX_PEND, (32'h1 << m) | (32'h1 << k));
    wr(OFS_RX_PEND, 32'h1 << m);
    rdc("flags", OFS_IRQ_FLAGS, 32'h200);
    wr(OFS_RX_PEND, 32'h1 << k);
    rdc("flags", OFS_IRQ_FLAGS, 32'h0);
    chk("irq", 32'h0, 32'(IRQ));
    cmrs_can_node_inst.receive(k, 1'b1);
    rdc("remote pending", OFS_REM_PEND, 32'h1 << k);
    bus(1'b0, OFS_IRQ_FLAGS, 32'h0);
    chk("remote flag", 32'h1, 32'(rd[10]));
    wr(OFS_REM_PEND, 32'h1 << k);
    bus(1'b0, OFS_IRQ_FLAGS, 32'h0);
    chk("remote flag", 32'h0, 32'(rd[10]));
    wr(OFS_RX_PEND, 32'hFFFF);
    wr(OFS_MB_MASK, 32'h1 << m);
    cmrs_can_node_inst.receive(m, 1'b0);
    rdc("flags", OFS_IRQ_FLAGS, 32'h0);
    cmrs_can_node_inst.receive(k, 1'b0);
    rdc("flags", OFS_IRQ_FLAGS, 32'h200);
    wr(OFS_IRQ_MASK, 32'hFFFF);
    rdc("unmapped", 12'h040, 32'h0);
    chk("irq", 32'h0, 32'(IRQ));
    for (int i = 0; i < 16; i++)
    begin
      wr(OFS_MSG_CTRL1, 32'(i));
      rdc("msg control", OFS_MSG_CTRL1, 32'(i));
      bus(1'b0, OFS_DECODE, 32'h0);
      chk("decode bytes", exp_bytes(i[3:0]), rd & 32'hF);
      chk("data bytes", exp_bytes(i[3:0]), 32'(DATA_BYTES));
    end
    for (int i = 0; i < 20; i++)
    begin
      rd = xs();
      bt = (i < 4) ? corner[i] : rd[15:0] & 16'h7F3F;
      e = exp_bt(bt);
      wr(OFS_BIT_TIME, 32'(bt));
      repeat (2) @(posedge CLK_SYS);
      bus(1'b0, OFS_DECODE, 32'h0);
      chk("timing decode", e, rd & 32'h1FFFE0);
      chk("timing ok", 32'(e[20]), 32'(BIT_TIME_OK));
      chk("quanta", 32'(e[19:15]), 32'(BIT_QUANTA));
    end
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_IRQ_FLAGS, 32'h1);
      wr(OFS_CONTROL, 32'h0);
      STANDBY_EXIT <= (i == 0);
      MODULE_STOP_EXIT <= (i == 1);
      repeat (2) @(posedge CLK_SYS);
      STANDBY_EXIT <= 1'b0;
      MODULE_STOP_EXIT <= 1'b0;
      repeat (6) @(posedge CLK_SYS);
      bus(1'b0, OFS_IRQ_FLAGS, 32'h0);
      chk("reset flag", 32'h1, 32'(rd[0]));
      chk("reset request", 32'(i == 0), 32'(RESET_MODE_REQ));
    end
    rdc("control", OFS_CONTROL, 32'h0);
    wr(OFS_CONTROL, 32'h1);
    repeat (2) @(posedge CLK_SYS);
    chk("reset request", 32'h1, 32'(RESET_MODE_REQ));
    summarize();
  end
endmodule : can_mailbox_rx_status_bench
